// ==== pkg/aicrf_regs.vh ====
// Register map, field widths, reset values and mux codes for the ADC
// input configuration and result formatting block.
// Included by the top-level design file; holds definitions only.
`ifndef AICRF_REGS_VH
`define AICRF_REGS_VH

// Special-function-register addresses.
`define AICRF_ADDR_PAIR_CFG   8'hba
`define AICRF_ADDR_CHAN_SEL   8'hbb
`define AICRF_ADDR_RES_LOW    8'hbe
`define AICRF_ADDR_RES_HIGH   8'hbf

// Reset values.
`define AICRF_RST_PAIR_CFG    4'h0
`define AICRF_RST_CHAN_SEL    4'h0
`define AICRF_RST_RES_BYTE    8'h00

// Field layout.
`define AICRF_CFG_BITS        4
`define AICRF_SEL_BITS        4
`define AICRF_RES_BITS        12

// Channel select code where the temperature sensor takes over.
`define AICRF_SEL_TEMP        4'h8

// Route codes driven to the analog mux: 0..7 single input, 8..11 pair, 12 temp.
`define AICRF_ROUTE_PAIR_BASE 4'h8
`define AICRF_ROUTE_TEMP      4'hc

`endif

// ==== rtl/aicrf_result_fmt.v ====
// Formats one 12-bit conversion word into the high and low result bytes.
// Assumes a conversion word that is already two's complement for pairs.
`timescale 1ns/100ps
`default_nettype none

module aicrf_result_fmt (
  // Conversion word and its kind.
  input  wire [11:0] conv_word,
  input  wire        is_diff,
  // Justification choice.
  input  wire        left_justify_sel,
  // Formatted bytes.
  output reg  [7:0]  high_byte,
  output reg  [7:0]  low_byte
);

  // Left: word in high byte and top nibble of low; right: sign or zero fill.
  always @* begin
    if (left_justify_sel) begin
      high_byte = conv_word[11:4];
      low_byte  = {conv_word[3:0], 4'h0};
    end else begin
      high_byte = {{4{is_diff & conv_word[11]}}, conv_word[11:8]};
      low_byte  = conv_word[7:0];
    end
  end

endmodule

`default_nettype wire

// ==== rtl/aicrf_top.v ====
// ADC input pair configuration, channel routing and result formatting.
// Assumes a byte-wide SFR port with one-cycle read and write strobes and a
// converter that pulses conv_done with its 12-bit word in the same cycle.
//
// Operation
// - Each config bit: 0 two single-ended inputs, 1 even-plus odd-minus pair.
// - Config register upper four bits read zero and ignore writes.
// - Either select code of a differential pair routes the pair; 1xxx routes temp.
// - Left justified: high byte holds result bits 11 to 4.
// - Right justified: high nibble sign-extends for pairs, zero for single-ended.
// - Left justified: low byte holds bits 3 to 0 above four zero bits.
// - Right justified: low byte holds result bits 7 to 0.
// - Differential results are two's complement; single-ended are unsigned.
// - Pair full scale gives 07ff/f800 right, 7ff0/8000 left justified.
// - A justification bit selects left or right placement of the result.
// - A four-bit channel select field chooses the routed input or pair.
`timescale 1ns/100ps
`default_nettype none
`include "aicrf_regs.vh"

module aicrf_top (
  // Clock and reset.
  input  wire       mclk,
  input  wire       rst_b,
  // Special-function-register port.
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  // Justification control bit held in the converter control register.
  input  wire       left_justify_sel,
  // Converter result.
  input  wire       conv_done,
  input  wire [11:0] conv_word,
  // Analog mux steering.
  output reg  [3:0] mux_route,
  output reg        mux_diff
);

  reg  [3:0] input_pair_config_reg;
  reg  [3:0] channel_select_reg;
  reg  [7:0] result_low_byte_reg;
  reg  [7:0] result_high_byte_reg;
  reg        conv_diff_reg;
  reg  [3:0] mux_route_next;
  reg        mux_diff_next;
  reg  [7:0] rdata_next;
  wire [7:0] fmt_high;
  wire [7:0] fmt_low;
  wire [1:0] pair_idx;
  wire       pair_is_diff;

  assign pair_idx     = channel_select_reg[2:1];
  assign pair_is_diff = input_pair_config_reg[pair_idx];

  // Routing: a pair set differential claims both of its codes.
  always @* begin
    if (channel_select_reg[3]) begin
      mux_route_next = `AICRF_ROUTE_TEMP;
      mux_diff_next  = 1'b0;
    end else if (pair_is_diff) begin
      mux_route_next = `AICRF_ROUTE_PAIR_BASE + {2'b00, pair_idx};
      mux_diff_next  = 1'b1;
    end else begin
      mux_route_next = channel_select_reg;
      mux_diff_next  = 1'b0;
    end
  end

  // Converter-word formatting; the word arrives already signed for pairs.
  aicrf_result_fmt u_fmt (
    .conv_word        (conv_word),
    .is_diff          (conv_diff_reg),
    .left_justify_sel (left_justify_sel),
    .high_byte        (fmt_high),
    .low_byte         (fmt_low)
  );

  // Register writes; the result bytes are software-writable, but a finishing
  // conversion wins so the pair never mixes two conversions.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      input_pair_config_reg <= `AICRF_RST_PAIR_CFG;
      channel_select_reg    <= `AICRF_RST_CHAN_SEL;
      result_low_byte_reg   <= `AICRF_RST_RES_BYTE;
      result_high_byte_reg  <= `AICRF_RST_RES_BYTE;
      conv_diff_reg         <= 1'b0;
    end else begin
      if (sfr_wr && sfr_addr == `AICRF_ADDR_PAIR_CFG)
        input_pair_config_reg <= sfr_wdata[3:0];
      if (sfr_wr && sfr_addr == `AICRF_ADDR_CHAN_SEL)
        channel_select_reg <= sfr_wdata[3:0];
      conv_diff_reg <= mux_diff_next;
      if (conv_done) begin
        result_high_byte_reg <= fmt_high;
        result_low_byte_reg  <= fmt_low;
      end else begin
        if (sfr_wr && sfr_addr == `AICRF_ADDR_RES_LOW)
          result_low_byte_reg <= sfr_wdata;
        if (sfr_wr && sfr_addr == `AICRF_ADDR_RES_HIGH)
          result_high_byte_reg <= sfr_wdata;
      end
    end
  end

  // Read mux; unmapped addresses return zero.
  always @* begin
    case (sfr_addr)
      `AICRF_ADDR_PAIR_CFG: rdata_next = {4'h0, input_pair_config_reg};
      `AICRF_ADDR_CHAN_SEL: rdata_next = {4'h0, channel_select_reg};
      `AICRF_ADDR_RES_LOW:  rdata_next = result_low_byte_reg;
      `AICRF_ADDR_RES_HIGH: rdata_next = result_high_byte_reg;
      default:              rdata_next = 8'h00;
    endcase
  end

  // Registered outputs; read data is held until the next read strobe.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
      mux_route <= 4'h0;
      mux_diff  <= 1'b0;
    end else begin
      if (sfr_rd)
        sfr_rdata <= rdata_next;
      mux_route <= mux_route_next;
      mux_diff  <= mux_diff_next;
    end
  end

endmodule

`default_nettype wire

// ==== tb/aicrf_asserts.sv ====
// Port checker for aicrf_top: result byte layout, config readback and mux routing.
// Assumes the config is stable for two cycles after each channel select write.
`timescale 1ns/100ps
`default_nettype none
module aicrf_chk (
  // Clock, reset and register port.
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [7:0]  sfr_addr,
  input wire logic [7:0]  sfr_wdata,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_rdata,
  // Converter and mux.
  input wire logic        left_justify_sel,
  input wire logic        conv_done,
  input wire logic [11:0] conv_word,
  input wire logic [3:0]  mux_route,
  input wire logic        mux_diff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // A result read on the cycle right after a conversion edge.
  sequence rd(j, a);
    conv_done && left_justify_sel == j ##1 sfr_rd && sfr_addr == a;
  endsequence
  a_left_high: assert property (rd(1, 8'hbf) |=> sfr_rdata == $past(conv_word[11:4], 2))
    else $error("left high byte");
  a_right_high: assert property (rd(0, 8'hbf) |=>
    sfr_rdata[3:0] == $past(conv_word[11:8], 2)
    && (sfr_rdata[7:4] == 4'h0 || sfr_rdata[7:4] == {4{$past(conv_word[11], 2)}}))
    else $error("right high byte");
  a_left_low: assert property (rd(1, 8'hbe) |=> sfr_rdata == {$past(conv_word[3:0], 2), 4'h0})
    else $error("left low byte");
  a_right_low: assert property (rd(0, 8'hbe) |=> sfr_rdata == $past(conv_word[7:0], 2))
    else $error("right low byte");
  a_cfg_upper_zero: assert property (sfr_rd && sfr_addr == 8'hba |=> sfr_rdata[7:4] == 4'h0)
    else $error("config upper bits");
  a_pair_diff: assert property (mux_diff == (mux_route[3:2] == 2'b10))
    else $error("pair flag");
  a_temp_route: assert property (sfr_wr && sfr_addr == 8'hbb && sfr_wdata[3] |=> ##1 mux_route == 4'hc)
    else $error("temp route");
  a_sel_route: assert property (sfr_wr && sfr_addr == 8'hbb && !sfr_wdata[3] |=>
    ##1 mux_route == (mux_diff ? {2'b10, $past(sfr_wdata[2:1], 2)} : $past(sfr_wdata[3:0], 2)))
    else $error("select route");
  // Main scenarios reached.
  cover property (rd(1, 8'hbf));
  cover property (rd(0, 8'hbe));
  cover property (mux_diff);
endmodule
`default_nettype wire

// ==== tb/aicrf_tb_top.sv ====
// Self-checking bench for aicrf_top: reset values, routing and result bytes.
// Assumes the design and the checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module aicrf_tb_top;
  logic        mclk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, left_justify_sel = 0, conv_done = 0;
  logic        mux_diff;
  logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic [11:0] conv_word = 0;
  logic [3:0]  mux_route;
  logic [31:0] r;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  aicrf_top u_dut (.*);
  // A 20 ns clock; a hang is cut short and counted as a mismatch.
  always #10 mclk = ~mclk;
  always @(negedge mclk)
    if (++cyc > 5000) begin
      fail_count++;
      give_verdict;
    end
  task chk(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e)
      $display("Error %s expected %h seen %h", n, e, g);
    if (g !== e)
      fail_count++;
  endtask
  // Writes wait two more cycles so the routing has settled.
  task wr(input logic [7:0] a, d);
    @(negedge mclk);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(negedge mclk);
    sfr_wr = 0;
    repeat (2) @(negedge mclk);
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge mclk);
    {sfr_addr, sfr_rd, conv_done} = {a, 2'b10};
    @(negedge mclk);
    sfr_rd = 0;
    chk("rdata", e, sfr_rdata);
  endtask
  function logic [7:0] rte(input logic [3:0] cf, sl);
    if (sl[3]) return 8'h0c;
    return cf[sl[2:1]] ? {4'h1, 2'b10, sl[2:1]} : {4'h0, sl};
  endfunction
  // Pair 0/1 set by d, then a conversion read back in the order picked by f.
  task cv(input logic [11:0] w, input logic j, d, f);
    logic [15:0] e;
    e = j ? {w, 4'h0} : {{4{d & w[11]}}, w};
    wr(8'hba, {7'h0, d});
    wr(8'hbb, 8'h00);
    left_justify_sel = j;
    @(negedge mclk);
    {conv_done, conv_word} = {1'b1, w};
    rd(8'hbe | f, f ? e[15:8] : e[7:0]);
    rd(8'hbf ^ f, f ? e[7:0] : e[15:8]);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Reset, register defaults, then random routing and conversions.
  initial begin
    void'($urandom(78));
    repeat (16) @(negedge mclk);
    rst_b = 1;
    for (int i = 0; i < 4; i++)
      rd(8'hba + {i[1], 1'b0, i[0]}, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'hba, 8'hf5);
    rd(8'hba, 8'h05);
    wr(8'hbf, 8'h5a);
    rd(8'hbf, 8'h5a);
    repeat (64) begin
      r = $urandom;
      wr(8'hba, r[7:0]);
      wr(8'hbb, r[15:8]);
      chk("route", rte(r[3:0], r[11:8]), {3'h0, mux_diff, mux_route});
    end
    for (int i = 0; i < 4; i++)
      cv(i[1] ? 12'h800 : 12'h7ff, i[0], 1'b1, i[0]);
    repeat (24) begin
      r = $urandom;
      cv(r[11:0], r[12], r[13], r[14]);
    end
    give_verdict;
  end
endmodule
bind aicrf_top aicrf_chk u_chk (.*);
`default_nettype wire
